// ---- rtl/hrxf_regs.svh ----
`ifndef HRXF_REGS_SVH
`define HRXF_REGS_SVH
// byte address = channel * 0x40 + word index * 4; channel 0 = D, 1/2 = B
`define HRXF_REG_FIFO 4'h0
`define HRXF_REG_MODE 4'h1
`define HRXF_REG_EXMODE 4'h2
`define HRXF_REG_CMD 4'h3
`define HRXF_REG_ISTAT 4'h4
`define HRXF_REG_COUNT 4'h5
`define HRXF_REG_MATCHH 4'h6
`define HRXF_REG_MATCHL 4'h7
// command bits
`define HRXF_CMD_RMC 0
`define HRXF_CMD_RECEIVER_RESET_CMD 1
// irq status bits
`define HRXF_IRQ_RPF 0
`define HRXF_IRQ_RME 1
`define HRXF_IRQ_RFO 2
// count word: overflow flag position
`define HRXF_OV_BIT 12
// data-overflow bit inside the status byte
`define HRXF_RDO_BIT 5
// message mode select codes
`define HRXF_MDS_NA1 3'h2
`define HRXF_MDS_NA2 3'h3
`define HRXF_MDS_XTP 3'h4
`define HRXF_MDS_TP2 3'h5
`define HRXF_MDS_TP0 3'h6
`define HRXF_MDS_TP1 3'h7
// address compare constants
`define HRXF_CR_MASK 8'hFD
`define HRXF_GRP_HIGH 8'hFC
`define HRXF_GRP_LOW 8'hFF
// reset values and block size bases
`define HRXF_MODE_RST 3'h6
`define HRXF_RX_BLOCK_SIZE_SEL_RST 2'h0
`define HRXF_BLK_D 7'h20
`define HRXF_BLK_B 7'h40
`endif

// ---- rtl/hrxf_pkg.sv ----
`default_nettype none
package hrxf_pkg;
  typedef enum logic [3:0] {
    PH_IDLE = 4'h1,
    PH_ADDR2 = 4'h2,
    PH_STORE = 4'h4,
    PH_DROP = 4'h8
  } hrxf_phase_e;
  typedef struct packed {
    logic isEnd;
    logic ov;
    logic [11:0] cnt;
    logic [6:0] len;
  } hrxf_entry_s;
endpackage
`default_nettype wire

// ---- rtl/hrxf_rx_filter.sv ----
// Our own choices: the register offsets and the APB register port.
`include "hrxf_regs.svh"
`default_nettype none
// Contract
// - D-channel: match two programmable SAPI, two TEI, group SAPI FE/FC, group TEI FF.
// - command/response bit of the received high byte is ignored when comparing.
// - B-channel: two programmable high, two low addresses, group FE/FC high, FF low.
// - modes 010/011: full address check, only bytes after the address are stored.
// - mode 110: no check, every byte after the opening flag is stored.
// - mode 111: first byte checked against high values, following bytes stored.
// - mode 101: second byte checked; D includes group FF, B programmable only.
// - mode 100: fully transparent, framing, CRC and stuffing disabled.
// - cyclic receive FIFO, 64 bytes for D, 128 for each B channel.
// - block size select: D 32/16/8/4, B 64/32/16/8; defaults 32 and 64.
// - pool-full raised when a full block is readable and the message continues.
// - message-end raised when a whole message or its final part is stored.
// - frame-overflow raised and frame discarded when FIFO is still occupied.
// - complete command frees the block and, at frame end, clears the count.
// - receiver reset empties FIFO and receiver; pending indications kept until read.
// - active block size is loaded on complete or receiver reset command.
// - 12-bit frame byte counter, overflow flag beyond 4095 bytes.
// - low count bits are bytes in last block; zero means a full block.
// - a status byte follows the last data byte of every accepted frame; the code does not store it while the block queue is full.
// - interrupts queue with count; next one raised as soon as host acknowledges.
// - bytes lost to a full FIFO set the data-overflow bit in the status byte.
// - over-reading repeats old data; unread data dropped on complete command.
module hrxf_rx_filter #(
  parameter int D_FIFO_DEPTH = 64,
  parameter int B_FIFO_DEPTH = 128,
  parameter int QUEUE_DEPTH = 4
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // received byte lanes from the deframers, lane 0 = D, 1 and 2 = B
  input wire logic [2:0] rxByteValid,
  input wire logic [23:0] rxByte,
  input wire logic [2:0] rxFrameEnd,
  input wire logic [23:0] rxStatus,
  // per-channel state
  output logic [2:0] transparentMode,
  output logic [2:0] rxIrqPending
);
  import hrxf_pkg::*;
  localparam int QW = $clog2(QUEUE_DEPTH);
  if (D_FIFO_DEPTH != 64 && D_FIFO_DEPTH != 128) begin : g_bad_d
    $error("D FIFO depth must be 64 or 128");
  end
  if (B_FIFO_DEPTH != 128) begin : g_bad_b
    $error("B FIFO depth must be 128");
  end
  if (QUEUE_DEPTH < 2 || QUEUE_DEPTH > 16 || (1 << QW) != QUEUE_DEPTH) begin : g_bad_q
    $error("queue depth must be a power of two from 2 to 16");
  end

  logic preadyQ;
  logic pslverrQ;
  logic [31:0] prdataQ;
  logic [31:0] chRd [3];

  wire logic accessWait = psel & penable & ~preadyQ;
  wire logic accessDone = psel & penable & preadyQ;
  wire logic [1:0] chSel = paddr[7:6];
  wire logic [3:0] regSel = paddr[5:2];
  wire logic unmapped = (chSel == 2'h3) | regSel[3];
  wire logic [31:0] rdMux = unmapped ? 32'h0 : chRd[chSel];

  // one wait state: decode settles before the answer is registered
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      preadyQ <= 1'b0;
      pslverrQ <= 1'b0;
      prdataQ <= 32'h0;
    end else if (ce) begin
      preadyQ <= accessWait;
      if (accessWait) begin
        prdataQ <= pwrite ? 32'h0 : rdMux;
        pslverrQ <= unmapped;
      end
    end
  end
  assign prdata = prdataQ;
  assign pready = preadyQ;
  assign pslverr = pslverrQ;
  for (genvar c = 0; c < 3; c++) begin : g_ch
    localparam int DEPTH = (c == 0) ? D_FIFO_DEPTH : B_FIFO_DEPTH;
    localparam logic [6:0] PMASK = 7'(DEPTH - 1);
    localparam logic [7:0] DEPTH8 = 8'(DEPTH);
    localparam logic [6:0] BBASE = (c == 0) ? `HRXF_BLK_D : `HRXF_BLK_B;

    logic [7:0] mem [128];
    hrxf_entry_s qMem [QUEUE_DEPTH];
    logic [2:0] modeQ;
    logic [1:0] rfbsQ;
    logic [6:0] bsizeQ;
    logic [15:0] matchHQ;
    logic [15:0] matchLQ;
    logic [2:0] istatQ;
    logic [2:0] istatD;
    logic [6:0] wpQ;
    logic [6:0] basePQ;
    logic [6:0] hpQ;
    logic [7:0] usedQ;
    logic [6:0] blkQ;
    logic [11:0] cntQ;
    logic ovQ;
    logic rdoQ;
    logic hiOkQ;
    logic hiOkD;
    logic shownQ;
    logic transpQ;
    logic irqQ;
    logic [QW-1:0] qWrQ;
    logic [QW-1:0] qRdQ;
    logic [QW:0] qCntQ;
    hrxf_phase_e phaseQ;
    hrxf_phase_e phaseD;
    logic storeByte;
    logic storeStat;
    logic rfoEv;
    logic rdoEv;

    wire logic rxV = rxByteValid[c];
    wire logic rxE = rxFrameEnd[c];
    wire logic [7:0] rxD = rxByte[c*8 +: 8];
    wire logic [7:0] rxS = rxStatus[c*8 +: 8];
    // register strobes act on the completing apb edge
    wire logic chHit = accessDone & (chSel == 2'(c)) & ~unmapped;
    wire logic wrMode = chHit & pwrite & (regSel == `HRXF_REG_MODE);
    wire logic wrExm = chHit & pwrite & (regSel == `HRXF_REG_EXMODE);
    wire logic wrCmd = chHit & pwrite & (regSel == `HRXF_REG_CMD);
    wire logic wrMatchH = chHit & pwrite & (regSel == `HRXF_REG_MATCHH);
    wire logic wrMatchL = chHit & pwrite & (regSel == `HRXF_REG_MATCHL);
    wire logic rdFifo = chHit & ~pwrite & (regSel == `HRXF_REG_FIFO);
    wire logic rdIstat = chHit & ~pwrite & (regSel == `HRXF_REG_ISTAT);
    wire logic rx_message_complete_cmd = wrCmd & pwdata[`HRXF_CMD_RMC];
    wire logic receiver_reset_cmd = wrCmd & pwdata[`HRXF_CMD_RECEIVER_RESET_CMD];
    // address compare, c/r bit masked off the high byte
    wire logic [7:0] rxHi = rxD & `HRXF_CR_MASK;
    wire logic hiMatch = (rxHi == (matchHQ[7:0] & `HRXF_CR_MASK))
                       | (rxHi == (matchHQ[15:8] & `HRXF_CR_MASK))
                       | (rxHi == `HRXF_GRP_HIGH);
    wire logic loProg = (rxD == matchLQ[7:0]) | (rxD == matchLQ[15:8]);
    wire logic loFull = loProg | (rxD == `HRXF_GRP_LOW);
    wire logic loTp2 = loProg | ((c == 0) & (rxD == `HRXF_GRP_LOW));
    // space and queue state
    wire logic [7:0] freeBytes = DEPTH8 - usedQ;
    wire logic qFull = qCntQ == (QW + 1)'(QUEUE_DEPTH);
    wire logic qAny = qCntQ != '0;
    wire logic room = (freeBytes > 8'h1) & ~qFull; // one slot kept for the status byte
    wire hrxf_entry_s head = qMem[qRdQ];
    wire logic pop = rx_message_complete_cmd & qAny;
    wire logic [6:0] headEnd = (basePQ + head.len) & PMASK;
    wire logic [6:0] readLimit = qAny ? headEnd : wpQ;
    wire logic [6:0] hpNext = (hpQ + 7'h1) & PMASK;
    wire logic hpAdv = rdFifo & (hpQ != readLimit) & (hpNext != readLimit);
    wire logic [6:0] blkInc = blkQ + 7'h1;
    wire logic [11:0] cntInc = cntQ + 12'h1;
    wire logic ovNext = ovQ | (cntQ == 12'hFFF);
    wire logic rpfEv = storeByte & (blkInc == bsizeQ);
    wire logic push = rpfEv | storeStat;
    wire logic wrEn = storeByte | storeStat;
    wire logic [7:0] statByte = rxS | (8'(rdoQ) << `HRXF_RDO_BIT);
    wire logic [7:0] wrData = storeStat ? statByte : rxD;
    wire hrxf_entry_s entry = storeStat ? {1'b1, ovNext, cntInc, blkInc}
                                        : {1'b0, ovNext, cntInc, bsizeQ};
    wire logic [6:0] bsizeSel = BBASE >> rfbsQ;
    wire logic [7:0] usedNext = usedQ + 8'(wrEn) - (pop ? {1'b0, head.len} : 8'h0);
    wire logic raiseHead = qAny & ~shownQ;
    wire logic [2:0] istatSet = {rfoEv, raiseHead & head.isEnd, raiseHead & ~head.isEnd};
    wire logic [12:0] countWord = qAny ? {head.ov, head.cnt} : 13'h0;

    // set wins over the read clear
    assign istatD = (rdIstat ? 3'h0 : istatQ) | istatSet;

    assign chRd[c] =
        (regSel == `HRXF_REG_FIFO) ? {24'h0, mem[hpQ]} :
        (regSel == `HRXF_REG_MODE) ? {29'h0, modeQ} :
        (regSel == `HRXF_REG_EXMODE) ? {30'h0, rfbsQ} :
        (regSel == `HRXF_REG_ISTAT) ? {29'h0, istatQ} :
        (regSel == `HRXF_REG_COUNT) ? {19'h0, countWord} :
        (regSel == `HRXF_REG_MATCHH) ? {16'h0, matchHQ} :
        (regSel == `HRXF_REG_MATCHL) ? {16'h0, matchLQ} : 32'h0;

    always_comb begin
      phaseD = phaseQ;
      hiOkD = hiOkQ;
      storeByte = 1'b0;
      storeStat = 1'b0;
      rfoEv = 1'b0;
      rdoEv = 1'b0;
      if (rxE && modeQ != `HRXF_MDS_XTP) begin
        storeStat = (phaseQ == PH_STORE) & (freeBytes != 8'h0) & ~qFull;
        phaseD = PH_IDLE;
      end else if (rxV) begin
        unique case (phaseQ)
          PH_IDLE: begin
            if (modeQ == `HRXF_MDS_XTP) begin
              storeByte = room;
              rdoEv = ~room;
            end else if (freeBytes < 8'h2) begin
              phaseD = PH_DROP;
              rfoEv = 1'b1;
            end else begin
              case (modeQ)
                `HRXF_MDS_TP0: begin
                  storeByte = room;
                  phaseD = PH_STORE;
                end
                `HRXF_MDS_NA1, `HRXF_MDS_TP1: phaseD = hiMatch ? PH_STORE : PH_DROP;
                `HRXF_MDS_NA2: begin
                  hiOkD = hiMatch;
                  phaseD = PH_ADDR2;
                end
                `HRXF_MDS_TP2: phaseD = PH_ADDR2;
                default: phaseD = PH_DROP;
              endcase
            end
          end
          PH_ADDR2: begin
            if (modeQ == `HRXF_MDS_NA2) begin
              phaseD = (hiOkQ & loFull) ? PH_STORE : PH_DROP;
            end else begin
              phaseD = loTp2 ? PH_STORE : PH_DROP;
            end
          end
          PH_STORE: begin
            storeByte = room;
            rdoEv = ~room;
          end
          PH_DROP: phaseD = PH_DROP;
        endcase
      end
    end

    // storage arrays carry no reset; pointers decide what is valid
    always_ff @(posedge ref_clk) begin
      if (ce && wrEn) begin
        mem[wpQ] <= wrData;
      end
      if (ce && push && !receiver_reset_cmd) begin
        qMem[qWrQ] <= entry;
      end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        modeQ <= `HRXF_MODE_RST;
        rfbsQ <= `HRXF_RX_BLOCK_SIZE_SEL_RST;
        matchHQ <= 16'h0;
        matchLQ <= 16'h0;
        istatQ <= 3'h0;
        irqQ <= 1'b0;
        transpQ <= 1'b0;
      end else if (ce) begin
        if (wrMode) begin
          modeQ <= pwdata[2:0];
        end
        if (wrExm) begin
          rfbsQ <= pwdata[1:0];
        end
        if (wrMatchH) begin
          matchHQ <= pwdata[15:0];
        end
        if (wrMatchL) begin
          matchLQ <= pwdata[15:0];
        end
        istatQ <= istatD;
        irqQ <= |istatD;
        transpQ <= modeQ == `HRXF_MDS_XTP;
      end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        bsizeQ <= BBASE;
        wpQ <= 7'h0;
        basePQ <= 7'h0;
        hpQ <= 7'h0;
        usedQ <= 8'h0;
        blkQ <= 7'h0;
        cntQ <= 12'h0;
        ovQ <= 1'b0;
        rdoQ <= 1'b0;
        hiOkQ <= 1'b0;
        shownQ <= 1'b0;
        qWrQ <= '0;
        qRdQ <= '0;
        qCntQ <= '0;
        phaseQ <= PH_IDLE;
      end else if (ce) begin
        if (rx_message_complete_cmd || receiver_reset_cmd) begin
          bsizeQ <= bsizeSel;
        end
        if (receiver_reset_cmd) begin
          wpQ <= 7'h0;
          basePQ <= 7'h0;
          hpQ <= 7'h0;
          usedQ <= 8'h0;
          blkQ <= 7'h0;
          cntQ <= 12'h0;
          ovQ <= 1'b0;
          rdoQ <= 1'b0;
          hiOkQ <= 1'b0;
          shownQ <= 1'b0;
          qWrQ <= '0;
          qRdQ <= '0;
          qCntQ <= '0;
          phaseQ <= PH_IDLE;
        end else begin
          phaseQ <= phaseD;
          hiOkQ <= hiOkD;
          usedQ <= usedNext;
          if (wrEn) begin
            wpQ <= (wpQ + 7'h1) & PMASK;
          end
          if (pop) begin
            basePQ <= headEnd;
            hpQ <= headEnd;
          end else if (hpAdv) begin
            hpQ <= (hpQ + 7'h1) & PMASK;
          end
          if (push) begin
            qWrQ <= qWrQ + QW'(1);
          end
          if (pop) begin
            qRdQ <= qRdQ + QW'(1);
          end
          qCntQ <= qCntQ + (QW + 1)'(push) - (QW + 1)'(pop);
          shownQ <= pop ? 1'b0 : qAny;
          if (storeStat || rpfEv) begin
            blkQ <= 7'h0;
          end else if (storeByte) begin
            blkQ <= blkInc;
          end
          if (storeStat) begin
            cntQ <= 12'h0;
            ovQ <= 1'b0;
          end else if (storeByte) begin
            cntQ <= cntInc;
            ovQ <= ovNext;
          end
          if (rxE) begin
            rdoQ <= 1'b0;
          end else if (rdoEv) begin
            rdoQ <= 1'b1;
          end
        end
      end
    end

    assign transparentMode[c] = transpQ;
    assign rxIrqPending[c] = irqQ;
  end
endmodule
`default_nettype wire

// ---- sim/hrxf_rx_filter_asserts.sv ----
`default_nettype none
module hrxf_rx_filter_asserts (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // lanes and state
  input wire logic [2:0] rxFrameEnd,
  input wire logic [2:0] transparentMode,
  input wire logic [2:0] rxIrqPending
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic [2:0] mode0_q;
  wire acc = psel && penable;
  wire istatRd = pready && !pwrite && paddr == 8'h10;
  wire unmapped = paddr[7:6] == 2'h3 || paddr[5];
  // shadow of the d-channel mode, only writes that the slave accepted
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mode0_q <= 3'h6;
    end else if (ce && pready && pwrite && paddr == 8'h04) begin
      mode0_q <= pwdata[2:0];
    end
  end
  ready_pulse_a: assert property (pready && ce |=> !pready)
    else $error("pready longer than one cycle");
  one_wait_a: assert property (acc && !pready && ce |=> pready)
    else $error("pready not after one wait state");
  ready_cause_a: assert property (pready |-> acc && $past(acc))
    else $error("pready outside an access");
  err_unmapped_a: assert property (pready |-> pslverr == unmapped)
    else $error("pslverr wrong for address");
  err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  mode_follow_a: assert property (transparentMode[0] == ($past(mode0_q) == 3'h4))
    else $error("transparent flag wrong");
  irq_on_end_a: assert property (rxFrameEnd[0] && ce && mode0_q == 3'h6
      |-> ##[1:4] rxIrqPending[0])
    else $error("no irq after frame end");
  irq_clear_a: assert property ($fell(rxIrqPending[0])
      |-> $past(istatRd) || $past(istatRd, 2))
    else $error("irq dropped without status read");
  freeze_a: assert property (!ce |=> $stable({pready, transparentMode, rxIrqPending}))
    else $error("state moved with ce low");
endmodule
bind hrxf_rx_filter hrxf_rx_filter_asserts chk_u (
  .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .rxFrameEnd(rxFrameEnd), .transparentMode(transparentMode),
  .rxIrqPending(rxIrqPending)
);
`default_nettype wire

// ---- sim/hrxf_host_model.sv ----
`default_nettype none
module hrxf_host_model (
  // clock
  input wire logic ref_clk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] rdData;
  logic rdErr;
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // request held until pready is seen high, released at that edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      testbench.fails++;
      testbench.give_verdict();
    end
  endtask
  // new block size only counts after a receiver reset or complete command; the mode applies at once
  task automatic setup(input logic [7:0] b, input logic [2:0] m, input logic [1:0] s);
    xfer(1'b1, b + 8'h04, {29'h0, m});
    xfer(1'b1, b + 8'h08, {30'h0, s});
    xfer(1'b1, b + 8'h0C, 32'h2);
  endtask
  task automatic ack(input logic [7:0] b);
    xfer(1'b1, b + 8'h0C, 32'h1);
  endtask
endmodule
`default_nettype wire

// ---- sim/testbench.sv ----
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, nrst, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, st;
  logic [31:0] pwdata, prdata, row;
  logic [2:0] rxByteValid, rxFrameEnd, transparentMode, rxIrqPending;
  logic [23:0] rxByte, rxStatus;
  logic [1:0] sel;
  logic [7:0] want[$];
  int fails, comparisons, seed, c, n, blk;
  // channel, mode, first byte, second byte, accepted
  logic [31:0] tbl[14] = '{32'h030E4301, 32'h03FEFF01, 32'h03FC2101, 32'h030C2200,
    32'h02100001, 32'h07FE9901, 32'h07502100, 32'h0577FF01, 32'h13465501,
    32'h1530FF00, 32'h15306701, 32'h17320001, 32'h23FCFF01, 32'h27FE0001};
  hrxf_rx_filter dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxByteValid(rxByteValid), .rxByte(rxByte), .rxFrameEnd(rxFrameEnd), .rxStatus(rxStatus),
    .transparentMode(transparentMode), .rxIrqPending(rxIrqPending)
  );
  hrxf_host_model host_u (
    .ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );
  always #4 ref_clk = ~ref_clk;
  function automatic logic [7:0] base(input int ch);
    return 8'(ch * 64);
  endfunction
  function automatic int skipOf(input logic [2:0] m);
    return m == 3'h6 ? 0 : (m == 3'h2 || m == 3'h7) ? 1 : 2;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    comparisons++;
    if (got !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host_u.xfer(1'b0, a, 32'h0);
    chk(host_u.rdData, e);
  endtask
  task automatic mk(input int k);
    want = {};
    repeat (k) want.push_back(8'($random(seed)));
    st = 8'($random(seed));
  endtask
  // released lanes show inverted data so stale bytes never look valid
  task automatic send(input int ch);
    foreach (want[i]) begin
      @(posedge ref_clk);
      rxByteValid[ch] <= 1'b1;
      rxByte[ch*8+:8] <= want[i];
    end
    @(posedge ref_clk);
    rxByteValid[ch] <= 1'b0;
    rxByte[ch*8+:8] <= ~rxByte[ch*8+:8];
    @(posedge ref_clk);
    rxFrameEnd[ch] <= 1'b1;
    rxStatus[ch*8+:8] <= st;
    @(posedge ref_clk);
    rxFrameEnd[ch] <= 1'b0;
    repeat (4) @(posedge ref_clk);
    want.push_back(st);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    seed = 32'hA72E4609;
    {ref_clk, nrst, ce, rxByteValid, rxFrameEnd, rxByte, rxStatus} = '0;
    fails = 0;
    comparisons = 0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    ce <= 1'b1;
    repeat (2) @(posedge ref_clk);
    ce <= 1'b0;
    repeat (3) @(posedge ref_clk);
    ce <= 1'b1;
    rd(8'h04, 32'h6);
    rd(8'h48, 32'h0);
    rd(8'h54, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'hC0, 32'h0);
    chk(32'(host_u.rdErr), 32'h1);
    rd(8'h20, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 3; i++) begin
      host_u.setup(base(i), 3'h4, 2'h0);
      chk(32'(transparentMode), 32'h1 << i);
      host_u.setup(base(i), 3'h6, 2'h0);
    end
    $display("transparent test done");
    repeat (6) begin
      c = $unsigned($random(seed)) % 3;
      sel = 2'($random(seed));
      blk = (c == 0 ? 32 : 64) >> sel;
      n = blk + 1 + $unsigned($random(seed)) % (blk - 3);
      host_u.setup(base(c), 3'h6, sel);
      mk(n);
      send(c);
      rd(base(c) + 8'h10, 32'h1);
      repeat (blk) rd(base(c), {24'h0, want.pop_front()});
      host_u.ack(base(c));
      rd(base(c) + 8'h10, 32'h2);
      rd(base(c) + 8'h14, 32'(n + 1));
      repeat (n + 1 - blk) rd(base(c), {24'h0, want.pop_front()});
      rd(base(c), {24'h0, st});
      host_u.ack(base(c));
      rd(base(c) + 8'h14, 32'h0);
    end
    $display("block test done");
    host_u.xfer(1'b1, 8'h18, 32'h100C);
    host_u.xfer(1'b1, 8'h1C, 32'h4321);
    host_u.xfer(1'b1, 8'h58, 32'h4430);
    host_u.xfer(1'b1, 8'h5C, 32'h6755);
    foreach (tbl[i]) begin
      row = tbl[i];
      c = row[31:28];
      host_u.setup(base(c), row[26:24], 2'h0);
      mk(5);
      want[0] = row[23:16];
      want[1] = row[15:8];
      send(c);
      repeat (row[0] ? skipOf(row[26:24]) : 6) void'(want.pop_front());
      rd(base(c) + 8'h10, {30'h0, row[0], 1'b0});
      rd(base(c) + 8'h14, 32'(want.size()));
      while (want.size() > 0) rd(base(c), {24'h0, want.pop_front()});
      if (row[0]) host_u.ack(base(c));
    end
    $display("address test done");
    host_u.setup(8'h00, 3'h6, 2'h0);
    // 66 bytes into 64: bytes 64 to 66 are lost, status keeps the overflow mark
    mk(66);
    send(0);
    repeat (32) rd(8'h00, {24'h0, want.pop_front()});
    host_u.ack(8'h00);
    rd(8'h14, 32'h40);
    repeat (31) rd(8'h00, {24'h0, want.pop_front()});
    rd(8'h00, {24'h0, st | 8'h20});
    host_u.ack(8'h00);
    rd(8'h10, 32'h3);
    mk(62);
    send(0);
    mk(3);
    send(0);
    host_u.xfer(1'b1, 8'h0C, 32'h2);
    rd(8'h10, 32'h5);
    rd(8'h14, 32'h0);
    $display("overflow test done");
    give_verdict();
  end
endmodule
`default_nettype wire
